// [include/exc_entry_map.svh]
// Purpose: Offsets, field positions, codes and reset values of the exception entry block
// Assumes: 32-bit Avalon-MM slave, byte addresses, one register per aligned word
// Notes:   Included by the design file, the monitor and the bench
`ifndef EXC_ENTRY_MAP_SVH
`define EXC_ENTRY_MAP_SVH

`define OFS_EVENT        6'h00
`define OFS_FAULT_ADDR   6'h04
`define OFS_PAGE_HI      6'h08
`define OFS_SAVED_PC     6'h0C
`define OFS_SAVED_SR     6'h10
`define OFS_SAVED_GR     6'h14
`define OFS_STATUS       6'h18
`define OFS_VECTOR_BASE  6'h1C
`define OFS_WDT_CTRL     6'h20
`define OFS_DEBUG_INSTR  6'h24

`define CODE_POWER_ON    12'h000
`define CODE_MANUAL      12'h020
`define CODE_TLB_MISS_RD 12'h040
`define CODE_TLB_MISS_WR 12'h060
`define CODE_INIT_WRITE  12'h080
`define CODE_MULTI_HIT   12'h140

`define RESET_VECTOR     32'hA0000000
`define VBR_RESET        32'h00000000
`define OFS_VEC_MISS     32'h00000400
`define OFS_VEC_GENERAL  32'h00000100

`define SR_MD_BIT        30
`define SR_RB_BIT        29
`define SR_BL_BIT        28
`define SR_FD_BIT        15
`define SR_IMASK_LSB     4
`define SR_IMASK_ONES    4'hF
`define SR_RESET         32'h700000F0

`define WDT_MODE_BIT     1
`define WDT_WATCHDOG_RESET_SELECT_BIT_BIT     0
`define DBG_RESET_NEG    4'h6
`define DBG_RESET_ASSERT 4'h7
`define PAGE_ENTRY_HIGH_REGISTER_ADDRESS_SPACE_IDENTIFIER_MASK   32'h000000FF
`define PAGE_ENTRY_HIGH_REGISTER_VPN_MASK    32'hFFFFFC00

`endif

// [include/exc_entry_pkg.sv]
// Purpose: Types shared by the exception entry block and its bench
// Assumes: Map header holds all numbers
// Notes:   Request group travels as one packed struct
package exc_entry_pkg;

    typedef enum logic [1:0] {
        RK_NONE,
        RK_POWER_ON,
        RK_MANUAL
    } reset_kind_t;

    typedef enum logic [2:0] {
        EV_NONE,
        EV_POWER_ON,
        EV_MANUAL,
        EV_MULTI_HIT,
        EV_GENERAL
    } event_kind_t;

    typedef struct packed {
        logic        instruction_tlb_multi;
        logic        operand_tlb_multi;
        logic        instruction_tlb_miss;
        logic        operand_tlb_miss;
        logic        init_write;
        logic        write_access;
        logic [31:0] vaddr;
        logic [31:0] pc;
        logic [31:0] r15;
    } exc_req_t;

endpackage

// [rtl/exc_entry.sv]
// Purpose: Reset selection and TLB exception entry for the core
// Assumes: All inputs but the asynchronous RESET_I synchronous to SYS_CLK_I; Avalon-MM slave at byte addresses
// Notes:   One cycle per event; PC_LOAD_O pulses with the new PC on PC_O
//
// The Avalon-MM register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "exc_entry_map.svh"

module exc_entry (
    // Clock and reset
    input  wire logic                    SYS_CLK_I,
    input  wire logic                    RESET_I,
    // Reset sources
    input  wire logic                    RST_PIN_N_I,
    input  wire logic                    RESET_KIND_SELECT_PIN_I,
    input  wire logic                    WDT_OVERFLOW_I,
    // Exception requests from pipeline and translation buffers
    input  wire exc_entry_pkg::exc_req_t EXC_REQ_I,
    // Register bus
    input  wire logic [5:0]              AVS_ADDRESS_I,
    input  wire logic                    AVS_READ_I,
    input  wire logic                    AVS_WRITE_I,
    input  wire logic [31:0]             AVS_WRITEDATA_I,
    output logic [31:0]                  AVS_READDATA_O,
    output logic                         AVS_WAITREQUEST_O,
    // Core side results
    output logic                         PC_LOAD_O,
    output logic [31:0]                  PC_O,
    output logic [31:0]                  STATUS_WORD_O,
    output exc_entry_pkg::reset_kind_t   INIT_KIND_O
);
    import exc_entry_pkg::*;

    logic        rst_pin_reg, rst_pin_next;
    logic        rst_prev_reg, rst_prev_next;
    logic        sel_reg, sel_next;
    logic        wdt_reg, wdt_next;
    logic        ack_reg, ack_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [11:0] event_reg, event_next;
    logic [31:0] fault_addr_reg, fault_addr_next;
    logic [31:0] page_hi_reg, page_hi_next;
    logic [31:0] saved_pc_reg, saved_pc_next;
    logic [31:0] saved_sr_reg, saved_sr_next;
    logic [31:0] saved_gr_reg, saved_gr_next;
    logic [31:0] status_reg, status_next;
    logic [31:0] vbr_reg, vbr_next;
    logic [1:0]  wdt_ctrl_reg, wdt_ctrl_next;
    logic [3:0]  dbg_reg, dbg_next;
    logic        pc_load_reg, pc_load_next;
    logic [31:0] pc_reg, pc_next;
    reset_kind_t init_reg, init_next;

    logic        bus_req;
    logic        wr_go;
    logic        pin_fall;
    logic        wdt_fire;
    logic        dbg_fire;
    logic        gen_req;
    logic        multi_req;
    event_kind_t ev;

    // Status word after entry; a full reset also restores mask and FPU enable
    function automatic logic [31:0] sr_on_entry(input logic [31:0] sr, input logic full);
        logic [31:0] v;
        v = sr;
        v[`SR_MD_BIT] = 1'b1;
        v[`SR_RB_BIT] = 1'b1;
        v[`SR_BL_BIT] = 1'b1;
        if (full) begin
            v[`SR_FD_BIT] = 1'b0;
            v[`SR_IMASK_LSB +: 4] = `SR_IMASK_ONES;
        end
        return v;
    endfunction

    // Register read mux; unmapped words read zero
    function automatic logic [31:0] reg_read(input logic [5:0] a);
        case (a)
            `OFS_EVENT:       reg_read = {20'h00000, event_reg};
            `OFS_FAULT_ADDR:  reg_read = fault_addr_reg;
            `OFS_PAGE_HI:     reg_read = page_hi_reg;
            `OFS_SAVED_PC:    reg_read = saved_pc_reg;
            `OFS_SAVED_SR:    reg_read = saved_sr_reg;
            `OFS_SAVED_GR:    reg_read = saved_gr_reg;
            `OFS_STATUS:      reg_read = status_reg;
            `OFS_VECTOR_BASE: reg_read = vbr_reg;
            `OFS_WDT_CTRL:    reg_read = {30'h00000000, wdt_ctrl_reg};
            `OFS_DEBUG_INSTR: reg_read = {28'h0000000, dbg_reg};
            default:          reg_read = 32'h00000000;
        endcase
    endfunction

    // Bus: one wait cycle, then answer
    assign bus_req           = AVS_READ_I | AVS_WRITE_I;
    assign AVS_WAITREQUEST_O = bus_req & ~ack_reg;
    assign wr_go             = AVS_WRITE_I & ack_reg;
    assign AVS_READDATA_O    = rdata_reg;

    // Event sources
    assign pin_fall  = rst_prev_reg & ~rst_pin_reg;
    assign wdt_fire  = wdt_reg & wdt_ctrl_reg[`WDT_MODE_BIT];
    assign dbg_fire  = wr_go && (AVS_ADDRESS_I == `OFS_DEBUG_INSTR)
                       && (AVS_WRITEDATA_I[3:0] == `DBG_RESET_NEG
                           || AVS_WRITEDATA_I[3:0] == `DBG_RESET_ASSERT);
    assign gen_req   = EXC_REQ_I.instruction_tlb_miss | EXC_REQ_I.operand_tlb_miss | EXC_REQ_I.init_write;
    assign multi_req = EXC_REQ_I.instruction_tlb_multi | EXC_REQ_I.operand_tlb_multi;

    // Resets outrank multiple hits, which outrank general exceptions
    always_comb begin
        ev = EV_NONE;
        if ((pin_fall & sel_reg) | (wdt_fire & ~wdt_ctrl_reg[`WDT_WATCHDOG_RESET_SELECT_BIT_BIT]) | dbg_fire)
            ev = EV_POWER_ON;
        else if ((pin_fall & ~sel_reg) | (wdt_fire & wdt_ctrl_reg[`WDT_WATCHDOG_RESET_SELECT_BIT_BIT]))
            ev = EV_MANUAL;
        else if (multi_req)
            ev = EV_MULTI_HIT;
        else if (gen_req & status_reg[`SR_BL_BIT])
            ev = EV_MANUAL;
        else if (gen_req)
            ev = EV_GENERAL;
    end

    always_comb begin
        rst_pin_next    = RST_PIN_N_I;
        rst_prev_next   = rst_pin_reg;
        sel_next        = RESET_KIND_SELECT_PIN_I;
        wdt_next        = WDT_OVERFLOW_I;
        ack_next        = bus_req & ~ack_reg;
        rdata_next      = ack_next ? reg_read(AVS_ADDRESS_I) : rdata_reg;
        event_next      = event_reg;
        fault_addr_next = fault_addr_reg;
        page_hi_next    = page_hi_reg;
        saved_pc_next   = saved_pc_reg;
        saved_sr_next   = saved_sr_reg;
        saved_gr_next   = saved_gr_reg;
        status_next     = status_reg;
        vbr_next        = vbr_reg;
        wdt_ctrl_next   = wdt_ctrl_reg;
        dbg_next        = dbg_reg;
        pc_load_next    = 1'b0;
        pc_next         = pc_reg;
        init_next       = RK_NONE;

        // Software writes first; a same-cycle event overrides below
        if (wr_go) begin
            case (AVS_ADDRESS_I)
                `OFS_FAULT_ADDR:  fault_addr_next = AVS_WRITEDATA_I;
                `OFS_PAGE_HI:     page_hi_next    = AVS_WRITEDATA_I;
                `OFS_SAVED_PC:    saved_pc_next   = AVS_WRITEDATA_I;
                `OFS_SAVED_SR:    saved_sr_next   = AVS_WRITEDATA_I;
                `OFS_SAVED_GR:    saved_gr_next   = AVS_WRITEDATA_I;
                `OFS_STATUS:      status_next     = AVS_WRITEDATA_I;
                `OFS_VECTOR_BASE: vbr_next        = AVS_WRITEDATA_I;
                `OFS_WDT_CTRL:    wdt_ctrl_next   = AVS_WRITEDATA_I[1:0];
                `OFS_DEBUG_INSTR: dbg_next        = AVS_WRITEDATA_I[3:0];
                default: begin
                end
            endcase
        end

        case (ev)
            EV_POWER_ON, EV_MANUAL, EV_MULTI_HIT: begin
                vbr_next     = `VBR_RESET;
                status_next  = sr_on_entry(status_reg, 1'b1);
                pc_next      = `RESET_VECTOR;
                pc_load_next = 1'b1;
                if (ev == EV_POWER_ON) begin
                    event_next = `CODE_POWER_ON;
                    init_next  = RK_POWER_ON;
                end else if (ev == EV_MANUAL) begin
                    event_next = `CODE_MANUAL;
                    init_next  = RK_MANUAL;
                end else begin
                    event_next      = `CODE_MULTI_HIT;
                    init_next       = RK_MANUAL;
                    fault_addr_next = EXC_REQ_I.vaddr;
                    page_hi_next    = (EXC_REQ_I.vaddr & `PAGE_ENTRY_HIGH_REGISTER_VPN_MASK)
                                      | (page_hi_reg & `PAGE_ENTRY_HIGH_REGISTER_ADDRESS_SPACE_IDENTIFIER_MASK);
                end
            end
            EV_GENERAL: begin
                fault_addr_next = EXC_REQ_I.vaddr;
                page_hi_next    = (EXC_REQ_I.vaddr & `PAGE_ENTRY_HIGH_REGISTER_VPN_MASK)
                                  | (page_hi_reg & `PAGE_ENTRY_HIGH_REGISTER_ADDRESS_SPACE_IDENTIFIER_MASK);
                saved_pc_next   = EXC_REQ_I.pc;
                saved_sr_next   = status_reg;
                saved_gr_next   = EXC_REQ_I.r15;
                status_next     = sr_on_entry(status_reg, 1'b0);
                pc_load_next    = 1'b1;
                // Instruction side ahead of data side
                if (EXC_REQ_I.instruction_tlb_miss) begin
                    event_next = `CODE_TLB_MISS_RD;
                    pc_next    = vbr_reg + `OFS_VEC_MISS;
                end else if (EXC_REQ_I.operand_tlb_miss) begin
                    event_next = EXC_REQ_I.write_access ? `CODE_TLB_MISS_WR
                                                        : `CODE_TLB_MISS_RD;
                    pc_next    = vbr_reg + `OFS_VEC_MISS;
                end else begin
                    event_next = `CODE_INIT_WRITE;
                    pc_next    = vbr_reg + `OFS_VEC_GENERAL;
                end
            end
            default: begin
            end
        endcase
    end

    // Hardware reset leaves the block as after a power-on reset
    always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            rst_pin_reg    <= 1'b1;
            rst_prev_reg   <= 1'b1;
            sel_reg        <= 1'b1;
            wdt_reg        <= 1'b0;
            ack_reg        <= 1'b0;
            rdata_reg      <= 32'h00000000;
            event_reg      <= `CODE_POWER_ON;
            fault_addr_reg <= 32'h00000000;
            page_hi_reg    <= 32'h00000000;
            saved_pc_reg   <= 32'h00000000;
            saved_sr_reg   <= 32'h00000000;
            saved_gr_reg   <= 32'h00000000;
            status_reg     <= `SR_RESET;
            vbr_reg        <= `VBR_RESET;
            wdt_ctrl_reg   <= 2'h0;
            dbg_reg        <= 4'h0;
            pc_load_reg    <= 1'b0;
            pc_reg         <= `RESET_VECTOR;
            init_reg       <= RK_NONE;
        end else begin
            rst_pin_reg    <= rst_pin_next;
            rst_prev_reg   <= rst_prev_next;
            sel_reg        <= sel_next;
            wdt_reg        <= wdt_next;
            ack_reg        <= ack_next;
            rdata_reg      <= rdata_next;
            event_reg      <= event_next;
            fault_addr_reg <= fault_addr_next;
            page_hi_reg    <= page_hi_next;
            saved_pc_reg   <= saved_pc_next;
            saved_sr_reg   <= saved_sr_next;
            saved_gr_reg   <= saved_gr_next;
            status_reg     <= status_next;
            vbr_reg        <= vbr_next;
            wdt_ctrl_reg   <= wdt_ctrl_next;
            dbg_reg        <= dbg_next;
            pc_load_reg    <= pc_load_next;
            pc_reg         <= pc_next;
            init_reg       <= init_next;
        end
    end

    assign PC_LOAD_O     = pc_load_reg;
    assign PC_O          = pc_reg;
    assign STATUS_WORD_O = status_reg;
    assign INIT_KIND_O   = init_reg;

endmodule // exc_entry

// [verification/exc_entry_monitor.sv]
// Purpose: Checker for the exception entry block ports
// Assumes: One clock domain, active-high asynchronous reset
// Notes:   Bound to exc_entry below the module
`timescale 1ns/10ps
`include "exc_entry_map.svh"
module exc_entry_monitor (
    // Clock and reset
    input wire logic                       SYS_CLK_I,
    input wire logic                       RESET_I,
    // Watched inputs
    input wire logic                       RST_PIN_N_I,
    input wire logic                       RESET_KIND_SELECT_PIN_I,
    input wire logic                       WDT_OVERFLOW_I,
    input wire logic                       AVS_WRITE_I,
    input wire exc_entry_pkg::exc_req_t    EXC_REQ_I,
    // Watched outputs
    input wire logic                       PC_LOAD_O,
    input wire logic [31:0]                PC_O,
    input wire logic [31:0]                STATUS_WORD_O,
    input wire exc_entry_pkg::reset_kind_t INIT_KIND_O
);
    import exc_entry_pkg::*;
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RESET_I);
    logic gen_req;
    logic multi_req;
    assign gen_req = EXC_REQ_I.instruction_tlb_miss | EXC_REQ_I.operand_tlb_miss | EXC_REQ_I.init_write;
    assign multi_req = EXC_REQ_I.instruction_tlb_multi | EXC_REQ_I.operand_tlb_multi;
    // Reset sources outrank requests, so only judge entries when they are idle
    sequence s_quiet;
        (RST_PIN_N_I && !WDT_OVERFLOW_I && !AVS_WRITE_I)[*3];
    endsequence
    sequence s_pin_fall(logic sel);
        $fell(RST_PIN_N_I) && RESET_KIND_SELECT_PIN_I == sel && $stable(RESET_KIND_SELECT_PIN_I);
    endsequence
    a_reset_pc: assert property (INIT_KIND_O != RK_NONE |-> PC_LOAD_O && PC_O == `RESET_VECTOR)
        else $error("reset entry without reset vector");
    a_reset_status: assert property (INIT_KIND_O != RK_NONE |-> STATUS_WORD_O[30:28] == 3'h7
        && !STATUS_WORD_O[`SR_FD_BIT] && STATUS_WORD_O[`SR_IMASK_LSB +: 4] == `SR_IMASK_ONES)
        else $error("reset entry with wrong status word");
    a_miss_entry: assert property (s_quiet ##0 (gen_req && !multi_req && !STATUS_WORD_O[`SR_BL_BIT])
        |=> PC_LOAD_O && INIT_KIND_O == RK_NONE && STATUS_WORD_O[30:28] == 3'h7)
        else $error("general entry missing or status bits not set");
    a_block_convert: assert property (s_quiet ##0 (gen_req && !multi_req && STATUS_WORD_O[`SR_BL_BIT])
        |=> INIT_KIND_O == RK_MANUAL && PC_O == `RESET_VECTOR)
        else $error("blocked exception not turned into manual reset");
    a_multi_manual: assert property (s_quiet ##0 multi_req |=> INIT_KIND_O == RK_MANUAL)
        else $error("multiple hit without manual initialisation");
    a_pin_power: assert property (s_pin_fall(1'b1) |-> ##2 INIT_KIND_O == RK_POWER_ON)
        else $error("pin fall with select high gave no power-on reset");
    a_pin_manual: assert property (s_pin_fall(1'b0) |-> ##2 INIT_KIND_O == RK_MANUAL)
        else $error("pin fall with select low gave no manual reset");
    a_pc_held: assert property (!PC_LOAD_O |-> $stable(PC_O))
        else $error("program counter moved without a load");
endmodule // exc_entry_monitor

bind exc_entry exc_entry_monitor i_exc_entry_monitor (
    .SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I), .RST_PIN_N_I(RST_PIN_N_I),
    .RESET_KIND_SELECT_PIN_I(RESET_KIND_SELECT_PIN_I), .WDT_OVERFLOW_I(WDT_OVERFLOW_I),
    .AVS_WRITE_I(AVS_WRITE_I), .EXC_REQ_I(EXC_REQ_I), .PC_LOAD_O(PC_LOAD_O), .PC_O(PC_O),
    .STATUS_WORD_O(STATUS_WORD_O), .INIT_KIND_O(INIT_KIND_O)
);

// [verification/exc_entry_far_model.sv]
// Purpose: Far side: pipeline, translation buffers, reset pins, watchdog
// Assumes: Bench commands arrive as a one-cycle go strobe
// Notes:   Released request flags clear; other request fields show inverted data, never stale values
`timescale 1ns/10ps
module exc_entry_far_model (
    // Clock and command
    input  wire logic                clk_i,
    input  wire logic                go_i,
    input  wire logic [1:0]          op_i,
    input  wire logic [4:0]          kind_i,
    input  wire logic                wr_i,
    input  wire logic [31:0]         va_i,
    // Toward the block
    output exc_entry_pkg::exc_req_t  req_o,
    output logic                     rst_pin_n_o,
    output logic                     sel_o,
    output logic                     wdt_o
);
    import exc_entry_pkg::*;
    initial begin
        req_o = '0;
        rst_pin_n_o = 1'b1;
        sel_o = 1'b1;
        wdt_o = 1'b0;
    end
    always @(posedge clk_i) begin
        if (go_i) begin
            case (op_i)
                2'h0: begin
                    req_o <= {kind_i, wr_i, va_i, ~va_i, va_i ^ 32'h5A5A5A5A};
                    @(posedge clk_i);
                    req_o <= {5'h00, ~req_o[96:0]};
                end
                2'h1, 2'h2: begin
                    sel_o <= (op_i == 2'h1);
                    repeat (2) @(posedge clk_i);
                    // Select stays put for the whole low pulse
                    rst_pin_n_o <= 1'b0;
                    repeat (5) @(posedge clk_i);
                    rst_pin_n_o <= 1'b1;
                end
                default: begin
                    wdt_o <= 1'b1;
                    @(posedge clk_i);
                    wdt_o <= 1'b0;
                end
            endcase
        end
    end
endmodule // exc_entry_far_model

// [verification/reset_and_tlb_exception_entry_tb_top.sv]
// Purpose: Self-checking bench for the exception entry block
// Assumes: 20 MHz clock; far model drives pins and requests
// Notes:   Row table for entries, then reset sources and corner cases
`timescale 1ns/10ps
`include "exc_entry_map.svh"
module reset_and_tlb_exception_entry_tb_top;
    import exc_entry_pkg::*;
    typedef struct packed {
        logic [4:0]  kind;
        logic        wr;
        logic [11:0] code;
        logic [31:0] pc;
        logic [31:0] sr;
        reset_kind_t init;
    } row_t;
    logic        sys_clk, reset, avs_read, avs_write, avs_waitrequest, pc_load;
    logic        rst_pin_n, sel_pin, wdt_ovf, m_go, m_wr;
    logic [5:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, pc, status_word, rdata, va, m_va;
    logic [1:0]  m_op;
    logic [4:0]  m_kind;
    exc_req_t    exc_req;
    reset_kind_t init_kind;
    int          mismatches, checks_done, cycles;
    row_t        rows [6];
    exc_entry i_exc_entry (
        .SYS_CLK_I(sys_clk), .RESET_I(reset), .RST_PIN_N_I(rst_pin_n),
        .RESET_KIND_SELECT_PIN_I(sel_pin), .WDT_OVERFLOW_I(wdt_ovf), .EXC_REQ_I(exc_req),
        .AVS_ADDRESS_I(avs_address), .AVS_READ_I(avs_read), .AVS_WRITE_I(avs_write),
        .AVS_WRITEDATA_I(avs_writedata), .AVS_READDATA_O(avs_readdata),
        .AVS_WAITREQUEST_O(avs_waitrequest), .PC_LOAD_O(pc_load), .PC_O(pc),
        .STATUS_WORD_O(status_word), .INIT_KIND_O(init_kind));
    exc_entry_far_model i_exc_entry_far_model (
        .clk_i(sys_clk), .go_i(m_go), .op_i(m_op), .kind_i(m_kind), .wr_i(m_wr), .va_i(m_va),
        .req_o(exc_req), .rst_pin_n_o(rst_pin_n), .sel_o(sel_pin), .wdt_o(wdt_ovf));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic give_verdict();
        if (mismatches == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Hang guard: the whole run needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            give_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic we, input logic [5:0] adr, input logic [31:0] wd);
        avs_address <= adr;
        avs_write <= we;
        avs_read <= !we;
        avs_writedata <= wd;
        // Only the hang guard ends a wait that never answers
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        chk({31'h0, avs_waitrequest}, 32'h0);
    endtask
    task automatic rd(input logic [5:0] adr, input logic [31:0] e);
        @(posedge sys_clk);
        bus(1'b0, adr, 32'h0);
        chk(rdata, e);
    endtask
    task automatic wr(input logic [5:0] adr, input logic [31:0] d);
        @(posedge sys_clk);
        bus(1'b1, adr, d);
    endtask
    task automatic fire(input logic [1:0] op, input logic [4:0] k, input logic w);
        @(posedge sys_clk);
        m_op <= op;
        m_kind <= k;
        m_wr <= w;
        m_va <= va;
        m_go <= 1'b1;
        @(posedge sys_clk);
        m_go <= 1'b0;
    endtask
    // Pulse seen right after an edge still shows the value of the cycle before it
    task automatic wait_load(input reset_kind_t k, input logic [31:0] p, input logic [31:0] s);
        int n;
        n = 0;
        while (pc_load !== 1'b1 && n < 12) begin
            @(posedge sys_clk);
            n++;
        end
        chk({31'h0, pc_load}, 32'h1);
        chk({30'h0, init_kind}, {30'h0, k});
        chk(pc, p);
        chk(status_word, s);
    endtask
    initial begin
        mismatches = 0;
        checks_done = 0;
        cycles = 0;
        reset = 1'b1;
        {avs_address, avs_read, avs_write, avs_writedata, m_go, m_op, m_kind, m_wr, va} = '0;
        rows = '{'{5'h04, 1'b0, 12'h040, 32'h8C000400, 32'h70000000, RK_NONE},
                 '{5'h02, 1'b0, 12'h040, 32'h8C000400, 32'h70000000, RK_NONE},
                 '{5'h02, 1'b1, 12'h060, 32'h8C000400, 32'h70000000, RK_NONE},
                 '{5'h01, 1'b1, 12'h080, 32'h8C000100, 32'h70000000, RK_NONE},
                 '{5'h10, 1'b0, 12'h140, `RESET_VECTOR, `SR_RESET, RK_MANUAL},
                 '{5'h08, 1'b1, 12'h140, `RESET_VECTOR, `SR_RESET, RK_MANUAL}};
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        chk(status_word, `SR_RESET);
        wr(`OFS_PAGE_HI, 32'h0000005A);
        for (int i = 0; i < 6; i++) begin
            va = {4'hC, i[3:0], 24'h3457AB};
            wr(`OFS_STATUS, 32'h0);
            wr(`OFS_VECTOR_BASE, 32'h8C000000);
            fire(2'h0, rows[i].kind, rows[i].wr);
            wait_load(rows[i].init, rows[i].pc, rows[i].sr);
            rd(`OFS_EVENT, {20'h0, rows[i].code});
            rd(`OFS_FAULT_ADDR, va);
            rd(`OFS_PAGE_HI, (va & `PAGE_ENTRY_HIGH_REGISTER_VPN_MASK) | 32'h5A);
            rd(`OFS_VECTOR_BASE, rows[i].init == RK_NONE ? 32'h8C000000 : 32'h0);
            if (rows[i].init == RK_NONE) begin
                rd(`OFS_SAVED_PC, ~va);
                rd(`OFS_SAVED_SR, 32'h0);
                rd(`OFS_SAVED_GR, va ^ 32'h5A5A5A5A);
            end
        end
        // Block bit left set by the last row
        va = 32'h11110000;
        fire(2'h0, 5'h04, 1'b0);
        wait_load(RK_MANUAL, `RESET_VECTOR, `SR_RESET);
        rd(`OFS_EVENT, 32'h20);
        wr(`OFS_STATUS, 32'h0);
        wr(`OFS_VECTOR_BASE, 32'h8C000000);
        fire(2'h0, 5'h07, 1'b1);
        wait_load(RK_NONE, 32'h8C000400, 32'h70000000);
        rd(`OFS_EVENT, 32'h40);
        for (int j = 0; j < 6; j++) begin
            wr(`OFS_STATUS, 32'h0);
            wr(`OFS_VECTOR_BASE, 32'h8C000000);
            wr(`OFS_WDT_CTRL, {30'h0, j[1:0]});
            if (j < 4) fire(j < 2 ? j[1:0] + 2'h1 : 2'h3, 5'h00, 1'b0);
            else wr(`OFS_DEBUG_INSTR, 32'(j + 2));
            wait_load((j == 1 || j == 3) ? RK_MANUAL : RK_POWER_ON, `RESET_VECTOR, `SR_RESET);
            rd(`OFS_EVENT, (j == 1 || j == 3) ? 32'h20 : 32'h0);
            rd(`OFS_VECTOR_BASE, 32'h0);
        end
        rd(6'h3C, 32'h0);
        wr(`OFS_EVENT, 32'h140);
        rd(`OFS_EVENT, 32'h0);
        // Mid-run reset must restore the power-on state without a load pulse
        wr(`OFS_VECTOR_BASE, 32'h8C000000);
        wr(`OFS_STATUS, 32'h0);
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        chk({31'h0, pc_load}, 32'h0);
        chk(pc, `RESET_VECTOR);
        chk(status_word, `SR_RESET);
        rd(`OFS_VECTOR_BASE, 32'h0);
        give_verdict();
    end
endmodule // reset_and_tlb_exception_entry_tb_top
